/* mabs_pkg.sv */
// Package for the single-operand execution block: opcodes, constants, carriers
package mabs_pkg;
    localparam int MABS_DW = 8;
    // Operation select from the decoder
    typedef enum logic [2:0] {
        MABS_OP_NONE = 3'b000,
        MABS_OP_INVERT_TO_WORKING = 3'b001,
        MABS_OP_BCD_ADJUST_AFTER_ADD = 3'b010,
        MABS_OP_SUBTRACT_ONE_MEMORY = 3'b011,
        MABS_OP_SUBTRACT_ONE_TO_WORKING = 3'b100,
        MABS_OP_POWER_DOWN = 3'b101,
        MABS_OP_ADD_ONE_MEMORY = 3'b110
    } mabs_op_t;
    localparam logic [3:0] MABS_NIB_MAX = 4'h9;
    localparam logic [7:0] MABS_ADJ_NONE = 8'h00;
    localparam logic [7:0] MABS_ADJ_LOW = 8'h06;
    localparam logic [7:0] MABS_ADJ_HIGH = 8'h60;
    localparam logic [7:0] MABS_ADJ_BOTH = 8'h66;
    localparam logic [7:0] MABS_ONE = 8'h01;
    localparam logic [7:0] MABS_ZERO = 8'h00;
    // Register addresses of the status word and working register, status bit positions and reset values
    localparam logic [3:0] MABS_REG_STATUS = 4'h0;
    localparam logic [3:0] MABS_REG_WORKING = 4'h4;
    localparam int MABS_BIT_ZERO = 0;
    localparam int MABS_BIT_CARRY = 1;
    localparam int MABS_BIT_NIBBLE = 2;
    localparam int MABS_BIT_EXPIRY = 3;
    localparam int MABS_BIT_SLEEP = 4;
    localparam int MABS_BIT_ASLEEP = 5;
    localparam logic [7:0] MABS_STATUS_RST = 8'h00;
    localparam logic [7:0] MABS_WORKING_RST = 8'h00;
    // Status flags carried together
    typedef struct packed {
        logic sleep_entered_flag;
        logic watchdog_expiry_flag;
        logic low_nibble_overflow_flag;
        logic hundreds_flag;
        logic null_flag;
    } mabs_flags_t;
    // Memory write request
    typedef struct packed {
        logic we;
        logic [7:0] data;
    } mabs_memwr_t;
endpackage

/* mabs_bcd_adj.sv */
// Decimal adjust of the working register after BCD addition
`timescale 1ns/10ps
module mabs_bcd_adj
    import mabs_pkg::*;
(
    input wire logic [7:0] value, // Working register value
    input wire logic nibble_ovf, // Low-nibble overflow flag
    input wire logic hundreds_in, // Hundreds-overflow flag in
    output logic [7:0] result, // Adjusted sum
    output logic hundreds_out // Hundreds-overflow flag out
);
    wire fix_low;
    wire fix_high;
    wire [7:0] addend;
    wire [8:0] sum;
    // Nibble checks and constant choice
    assign fix_low = (value[3:0] > MABS_NIB_MAX) || nibble_ovf;
    assign fix_high = (value[7:4] > MABS_NIB_MAX) || hundreds_in;
    assign addend = fix_low ? (fix_high ? MABS_ADJ_BOTH : MABS_ADJ_LOW)
                            : (fix_high ? MABS_ADJ_HIGH : MABS_ADJ_NONE);
    assign sum = {1'b0, value} + {1'b0, addend};
    assign result = sum[7:0];
    // Only set by a high correction carrying out, never cleared here
    assign hundreds_out = hundreds_in | (fix_high & sum[8]);
endmodule // mabs_bcd_adj

/* mabs_core.sv */
// Execution of the single-operand instruction group with its status flags
// How it works
// - invert_to_working puts the inverted memory byte into working register, updates zero flag.
// - BCD adjust adds 6 to low nibble if above 9 or nibble flag set.
// - BCD adjust adds 6 to high nibble if above 9 or hundreds flag set.
// - BCD adjust adds 00h, 06h, 60h or 66h; sum goes to memory.
// - BCD adjust touches only the hundreds flag, set on decimal sum of 100+, but not for 9Ah-9Fh.
// - subtract_one_memory writes memory minus one back, zero flag only.
// - subtract_one_to_working writes memory minus one into working register, zero flag only.
// - Power-down halts execution and gates the clock; state is kept.
// - Power-down clears the watchdog counter and its prescaler.
// - Power-down sets sleep flag, clears expiry flag, nothing else.
// - add_one_memory writes memory plus one back.
// - add_one_memory updates zero flag only.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module mabs_core
    import mabs_pkg::*;
#(
    parameter int DW = MABS_DW // Data width; the datapath serves 8 only
)
(
    input wire logic clk_sys, // Core clock
    input wire logic srst, // Synchronous reset, active high
    input wire mabs_op_t op, // Operation strobe, one cycle
    input wire logic [7:0] mem_rdata, // Addressed data memory byte
    input wire logic wake, // Wake-up request ends power-down
    input wire logic set_carry, // Other instructions load hundreds flag
    input wire logic carry_val, // Value for hundreds flag load
    input wire logic set_nibble, // Other instructions load nibble flag
    input wire logic nibble_val, // Value for nibble flag load
    input wire logic [3:0] reg_addr, // Register port address
    input wire logic [7:0] reg_wdata, // Register port write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    output mabs_memwr_t mem_wr, // Memory write request
    output logic [7:0] working_register, // Working register
    output mabs_flags_t flags, // Status flags
    output logic watchdog_counter_clear, // Pulse clearing watchdog and prescaler
    output logic sys_clk_gate, // High while the system clock is stopped
    output logic exec_halted // High while execution is halted
);
    wire [7:0] inv_val;
    wire [7:0] dec_val;
    wire [7:0] inc_val;
    wire [7:0] bcd_val;
    wire bcd_hund;
    wire is_inv;
    wire is_bcd;
    wire is_decm;
    wire is_subtract_one_to_working;
    wire is_incm;
    wire is_pd;
    wire op_ok;
    wire zero_upd;
    logic [7:0] zsrc;
    logic [7:0] next_working;
    mabs_flags_t next_flags;
    mabs_memwr_t next_memwr;
    logic asleep;
    wire [7:0] status_word;
    logic wake_meta;
    logic wake_sync;

    // Refuse a width that the byte-wide datapath cannot serve
    if (DW != MABS_DW) begin : g_bad_width
        $error("mabs_core serves an 8-bit data width only");
    end

    // Wake request comes from logic that runs while this clock is stopped
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            wake_meta <= wake;
            wake_sync <= wake_meta;
        end
    end

    // Decode, ignored while asleep
    assign op_ok = !asleep;
    assign is_inv = op_ok && (op == MABS_OP_INVERT_TO_WORKING);
    assign is_bcd = op_ok && (op == MABS_OP_BCD_ADJUST_AFTER_ADD);
    assign is_decm = op_ok && (op == MABS_OP_SUBTRACT_ONE_MEMORY);
    assign is_subtract_one_to_working = op_ok && (op == MABS_OP_SUBTRACT_ONE_TO_WORKING);
    assign is_pd = op_ok && (op == MABS_OP_POWER_DOWN);
    assign is_incm = op_ok && (op == MABS_OP_ADD_ONE_MEMORY);

    // Arithmetic results
    assign inv_val = ~mem_rdata;
    assign dec_val = mem_rdata - MABS_ONE;
    assign inc_val = mem_rdata + MABS_ONE;

    mabs_bcd_adj u_bcd (
        .value(working_register),
        .nibble_ovf(flags.low_nibble_overflow_flag),
        .hundreds_in(flags.hundreds_flag),
        .result(bcd_val),
        .hundreds_out(bcd_hund)
    );

    // Zero-flag source
    assign zero_upd = is_inv || is_decm || is_subtract_one_to_working || is_incm;
    always_comb begin
        zsrc = MABS_ZERO;
        if (is_inv) begin
            zsrc = inv_val;
        end else if (is_decm || is_subtract_one_to_working) begin
            zsrc = dec_val;
        end else if (is_incm) begin
            zsrc = inc_val;
        end
    end

    // Next working register
    always_comb begin
        next_working = working_register;
        if (reg_wr && reg_addr == MABS_REG_WORKING) begin
            next_working = reg_wdata;
        end
        if (is_inv) begin
            next_working = inv_val;
        end else if (is_subtract_one_to_working) begin
            next_working = dec_val;
        end
    end

    // Memory write request
    always_comb begin
        next_memwr = '0;
        if (is_bcd) begin
            next_memwr = '{we: 1'b1, data: bcd_val};
        end else if (is_decm) begin
            next_memwr = '{we: 1'b1, data: dec_val};
        end else if (is_incm) begin
            next_memwr = '{we: 1'b1, data: inc_val};
        end
    end

    // Next flags
    always_comb begin
        next_flags = flags;
        if (set_carry) begin
            next_flags.hundreds_flag = carry_val;
        end
        if (set_nibble) begin
            next_flags.low_nibble_overflow_flag = nibble_val;
        end
        if (zero_upd) begin
            next_flags.null_flag = (zsrc == MABS_ZERO);
        end
        if (is_bcd) begin
            next_flags.hundreds_flag = bcd_hund;
        end
        if (is_pd) begin
            next_flags.sleep_entered_flag = 1'b1;
            next_flags.watchdog_expiry_flag = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            working_register <= MABS_WORKING_RST;
            flags <= mabs_flags_t'(MABS_STATUS_RST[4:0]);
            mem_wr <= '0;
            watchdog_counter_clear <= 1'b0;
            asleep <= 1'b0;
        end else begin
            working_register <= next_working;
            flags <= next_flags;
            mem_wr <= next_memwr;
            watchdog_counter_clear <= is_pd;
            if (is_pd) begin
                asleep <= 1'b1;
            end else if (wake_sync) begin
                asleep <= 1'b0;
            end
        end
    end

    // Halt and clock gating follow the sleep state
    assign sys_clk_gate = asleep;
    assign exec_halted = asleep;

    // Register read port
    assign status_word = {2'b00, asleep, flags.sleep_entered_flag,
                          flags.watchdog_expiry_flag, flags.low_nibble_overflow_flag,
                          flags.hundreds_flag, flags.null_flag};
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= MABS_ZERO;
        end else if (reg_rd && reg_addr == MABS_REG_STATUS) begin
            reg_rdata <= status_word;
        end else if (reg_rd && reg_addr == MABS_REG_WORKING) begin
            reg_rdata <= working_register;
        end else begin
            reg_rdata <= MABS_ZERO;
        end
    end

    // Checks
    property p_inv;
        @(posedge clk_sys) disable iff (srst)
        is_inv |=> (working_register == ~$past(mem_rdata)) && !mem_wr.we;
    endproperty
    a_inv: assert property (p_inv) else $error("invert result wrong");

    property p_bcd_low;
        @(posedge clk_sys) disable iff (srst)
        (is_bcd && working_register[3:0] > MABS_NIB_MAX && working_register[7:4] < MABS_NIB_MAX
            && !flags.hundreds_flag)
        |=> mem_wr.we && (mem_wr.data[3:0] == $past(working_register[3:0]) + MABS_ADJ_LOW[3:0]);
    endproperty
    a_bcd_low: assert property (p_bcd_low) else $error("bcd low fix wrong");

    property p_bcd_high;
        @(posedge clk_sys) disable iff (srst)
        (is_bcd && working_register[7:4] > MABS_NIB_MAX && working_register[3:0] < MABS_NIB_MAX
            && !flags.low_nibble_overflow_flag)
        |=> mem_wr.data == $past(working_register) + MABS_ADJ_HIGH;
    endproperty
    a_bcd_high: assert property (p_bcd_high) else $error("bcd high fix wrong");

    property p_bcd_keep;
        @(posedge clk_sys) disable iff (srst)
        (is_bcd && flags.hundreds_flag && !set_carry) |=> flags.hundreds_flag
            && $stable(flags.null_flag) && $stable(working_register);
    endproperty
    a_bcd_keep: assert property (p_bcd_keep) else $error("bcd cleared flag");

    property p_decm;
        @(posedge clk_sys) disable iff (srst)
        is_decm |=> mem_wr.we && mem_wr.data == $past(mem_rdata) - MABS_ONE
            && flags.null_flag == ($past(mem_rdata) == MABS_ONE);
    endproperty
    a_decm: assert property (p_decm) else $error("decrement memory wrong");

    property p_subtract_one_to_working;
        @(posedge clk_sys) disable iff (srst)
        is_subtract_one_to_working |=> !mem_wr.we && working_register == $past(mem_rdata) - MABS_ONE;
    endproperty
    a_subtract_one_to_working: assert property (p_subtract_one_to_working) else $error("decrement to working wrong");

    property p_pd;
        @(posedge clk_sys) disable iff (srst)
        is_pd |=> flags.sleep_entered_flag && !flags.watchdog_expiry_flag
            && watchdog_counter_clear && exec_halted && $stable(working_register);
    endproperty
    a_pd: assert property (p_pd) else $error("power-down effects wrong");

    property p_inc;
        @(posedge clk_sys) disable iff (srst)
        (is_incm && !set_carry && !set_nibble) |=> mem_wr.data == $past(mem_rdata) + MABS_ONE
            && $stable(flags.hundreds_flag) && $stable(flags.sleep_entered_flag);
    endproperty
    a_inc: assert property (p_inc) else $error("increment memory wrong");

    property p_inv_null;
        @(posedge clk_sys) disable iff (srst)
        is_inv |=> flags.null_flag == (~$past(mem_rdata) == MABS_ZERO);
    endproperty
    a_inv_null: assert property (p_inv_null) else $error("invert zero flag wrong");

    property p_subtract_one_to_working_null;
        @(posedge clk_sys) disable iff (srst)
        is_subtract_one_to_working |=> flags.null_flag == ($past(mem_rdata) == MABS_ONE);
    endproperty
    a_subtract_one_to_working_null: assert property (p_subtract_one_to_working_null) else $error("decrement zero flag wrong");

    property p_inc_null;
        @(posedge clk_sys) disable iff (srst)
        is_incm |=> mem_wr.we && flags.null_flag == (~$past(mem_rdata) == MABS_ZERO);
    endproperty
    a_inc_null: assert property (p_inc_null) else $error("increment zero flag wrong");

    property p_subtract_one_to_working_flags;
        @(posedge clk_sys) disable iff (srst)
        (is_subtract_one_to_working && !set_carry && !set_nibble) |=> $stable(flags.hundreds_flag)
            && $stable(flags.low_nibble_overflow_flag) && $stable(flags.sleep_entered_flag);
    endproperty
    a_subtract_one_to_working_flags: assert property (p_subtract_one_to_working_flags) else $error("decrement touched flags");

    property p_decm_flags;
        @(posedge clk_sys) disable iff (srst)
        (is_decm && !set_carry && !set_nibble) |=> $stable(flags.hundreds_flag)
            && $stable(flags.low_nibble_overflow_flag) && $stable(working_register);
    endproperty
    a_decm_flags: assert property (p_decm_flags) else $error("memory decrement side effect");

    property p_bcd_none;
        @(posedge clk_sys) disable iff (srst)
        (is_bcd && working_register[3:0] <= MABS_NIB_MAX && working_register[7:4] <= MABS_NIB_MAX
            && !flags.low_nibble_overflow_flag && !flags.hundreds_flag)
        |=> mem_wr.we && mem_wr.data == $past(working_register);
    endproperty
    a_bcd_none: assert property (p_bcd_none) else $error("bcd changed a valid value");

    property p_bcd_both;
        @(posedge clk_sys) disable iff (srst)
        (is_bcd && working_register[3:0] > MABS_NIB_MAX && working_register[7:4] > MABS_NIB_MAX)
        |=> mem_wr.data == $past(working_register) + MABS_ADJ_BOTH;
    endproperty
    a_bcd_both: assert property (p_bcd_both) else $error("bcd double fix wrong");

    property p_bcd_set;
        @(posedge clk_sys) disable iff (srst)
        (is_bcd && working_register[7:4] > MABS_NIB_MAX) |=> flags.hundreds_flag;
    endproperty
    a_bcd_set: assert property (p_bcd_set) else $error("bcd hundreds not set");

    property p_bcd_clear_stays;
        @(posedge clk_sys) disable iff (srst)
        (is_bcd && !flags.hundreds_flag && working_register[7:4] <= MABS_NIB_MAX)
        |=> !flags.hundreds_flag;
    endproperty
    a_bcd_clear_stays: assert property (p_bcd_clear_stays) else $error("bcd hundreds set");

    property p_bcd_other;
        @(posedge clk_sys) disable iff (srst)
        (is_bcd && !set_nibble) |=> $stable(flags.low_nibble_overflow_flag)
            && $stable(flags.sleep_entered_flag) && $stable(flags.null_flag);
    endproperty
    a_bcd_other: assert property (p_bcd_other) else $error("bcd touched other flags");

    property p_pd_only;
        @(posedge clk_sys) disable iff (srst)
        (is_pd && !set_carry && !set_nibble) |=> $stable(flags.null_flag)
            && $stable(flags.hundreds_flag) && $stable(flags.low_nibble_overflow_flag);
    endproperty
    a_pd_only: assert property (p_pd_only) else $error("power-down touched flags");

    property p_clear_src;
        @(posedge clk_sys) disable iff (srst)
        watchdog_counter_clear |-> exec_halted && $past(op == MABS_OP_POWER_DOWN);
    endproperty
    a_clear_src: assert property (p_clear_src) else $error("stray watchdog clear");

    property p_asleep_ignore;
        @(posedge clk_sys) disable iff (srst)
        (exec_halted && op != MABS_OP_NONE) |=> !mem_wr.we && !watchdog_counter_clear;
    endproperty
    a_asleep_ignore: assert property (p_asleep_ignore) else $error("op ran while asleep");

    property p_asleep_keep;
        @(posedge clk_sys) disable iff (srst)
        (exec_halted && !reg_wr) |=> $stable(working_register);
    endproperty
    a_asleep_keep: assert property (p_asleep_keep) else $error("working changed asleep");

    property p_halt_stay;
        @(posedge clk_sys) disable iff (srst)
        (exec_halted && !wake_sync) |=> exec_halted;
    endproperty
    a_halt_stay: assert property (p_halt_stay) else $error("halt left without wake");
endmodule // mabs_core

/* mabs_core_test.sv */
// Self-checking bench for the single-operand execution block
`timescale 1ns/10ps
module mabs_core_test;
    import mabs_pkg::*;
    // One table row: operation, inputs, preloads and expected results
    typedef struct packed {
        mabs_op_t op;
        logic [7:0] m;
        logic [7:0] w;
        logic [4:0] ctl; // nibble, hundreds in, write, null out, hundreds out
        logic [7:0] data;
        logic [7:0] work;
    } mabs_row_t;
    logic clk_sys, srst, wake, set_carry, carry_val, set_nibble, nibble_val, reg_wr, reg_rd;
    mabs_op_t op;
    logic [7:0] mem_rdata, reg_wdata, reg_rdata, working_register;
    logic [3:0] reg_addr;
    mabs_memwr_t mem_wr;
    mabs_flags_t flags;
    logic watchdog_counter_clear, sys_clk_gate, exec_halted;
    int n_fail = 0;
    int cmp_count = 0;
    mabs_row_t rows [16] = '{
        '{MABS_OP_INVERT_TO_WORKING, 8'hff, 8'h12, 5'h02, 8'h00, 8'h00},
        '{MABS_OP_INVERT_TO_WORKING, 8'ha5, 8'h00, 5'h00, 8'h00, 8'h5a},
        '{MABS_OP_SUBTRACT_ONE_MEMORY, 8'h01, 8'h33, 5'h06, 8'h00, 8'h33},
        '{MABS_OP_SUBTRACT_ONE_MEMORY, 8'h00, 8'h33, 5'h04, 8'hff, 8'h33},
        '{MABS_OP_SUBTRACT_ONE_TO_WORKING, 8'h01, 8'h77, 5'h02, 8'h00, 8'h00},
        '{MABS_OP_SUBTRACT_ONE_TO_WORKING, 8'h80, 8'h77, 5'h00, 8'h00, 8'h7f},
        '{MABS_OP_ADD_ONE_MEMORY, 8'hff, 8'h11, 5'h0f, 8'h00, 8'h11},
        '{MABS_OP_BCD_ADJUST_AFTER_ADD, 8'h00, 8'h12, 5'h06, 8'h12, 8'h12},
        '{MABS_OP_BCD_ADJUST_AFTER_ADD, 8'h00, 8'h1a, 5'h06, 8'h20, 8'h1a},
        '{MABS_OP_BCD_ADJUST_AFTER_ADD, 8'h00, 8'h12, 5'h16, 8'h18, 8'h12},
        '{MABS_OP_BCD_ADJUST_AFTER_ADD, 8'h00, 8'ha2, 5'h07, 8'h02, 8'ha2},
        '{MABS_OP_BCD_ADJUST_AFTER_ADD, 8'h00, 8'h22, 5'h0f, 8'h82, 8'h22},
        '{MABS_OP_BCD_ADJUST_AFTER_ADD, 8'h00, 8'hab, 5'h07, 8'h11, 8'hab},
        '{MABS_OP_BCD_ADJUST_AFTER_ADD, 8'h00, 8'h99, 5'h1f, 8'hff, 8'h99},
        '{MABS_OP_BCD_ADJUST_AFTER_ADD, 8'h00, 8'h00, 5'h06, 8'h00, 8'h00},
        '{MABS_OP_ADD_ONE_MEMORY, 8'h7f, 8'h11, 5'h04, 8'h80, 8'h11}
    };

    mabs_core dut_u (.clk_sys(clk_sys), .srst(srst), .op(op), .mem_rdata(mem_rdata),
        .wake(wake), .set_carry(set_carry), .carry_val(carry_val), .set_nibble(set_nibble),
        .nibble_val(nibble_val), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_wr(mem_wr),
        .working_register(working_register), .flags(flags),
        .watchdog_counter_clear(watchdog_counter_clear), .sys_clk_gate(sys_clk_gate),
        .exec_halted(exec_halted));

    // Clock generation
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("counts: %0d compared, %0d wrong", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Every output at its reset value
    task automatic chk_idle;
        chk("reg_rdata", 8'h00, reg_rdata);
        chk("mem_wr", 8'h00, {mem_wr.we, mem_wr.data[6:0]} | mem_wr.data);
        chk("working_register", 8'h00, working_register);
        chk("flags", 8'h00, {3'h0, flags});
        chk("side outputs", 8'h00, {5'h0, watchdog_counter_clear, sys_clk_gate, exec_halted});
    endtask

    // Issue one operation, then settle after the answering edge
    task automatic do_op(input mabs_op_t o, input logic [7:0] m);
        op <= o;
        mem_rdata <= m;
        @(posedge clk_sys);
        op <= MABS_OP_NONE;
        #1;
    endtask

    // Register read; data only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
        @(posedge clk_sys);
        #1;
        chk("reg_rdata after", 8'h00, reg_rdata);
    endtask

    // Preload working register and flags, then run one table row
    task automatic run_row(input mabs_row_t r);
        reg_addr <= MABS_REG_WORKING;
        reg_wdata <= r.w;
        reg_wr <= 1'h1;
        set_carry <= 1'h1;
        carry_val <= r.ctl[3];
        set_nibble <= 1'h1;
        nibble_val <= r.ctl[4];
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        set_carry <= 1'h0;
        set_nibble <= 1'h0;
        do_op(r.op, r.m);
        chk("mem_wr.we", {7'h0, r.ctl[2]}, {7'h0, mem_wr.we});
        if (r.ctl[2]) begin
            chk("mem_wr.data", r.data, mem_wr.data);
        end
        chk("working_register", r.work, working_register);
        chk("flags", {5'h0, r.ctl[4], r.ctl[0], r.ctl[1]}, {3'h0, flags});
        @(posedge clk_sys);
        #1;
        chk("mem_wr.we later", 8'h00, {7'h0, mem_wr.we});
    endtask

    // Watchdog against a hang
    initial begin
        #20000;
        n_fail++;
        close_out();
    end

    // Main sequence
    initial begin
        srst = 1'h1;
        wake = 1'h0;
        set_carry = 1'h0;
        carry_val = 1'h0;
        set_nibble = 1'h0;
        nibble_val = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        op = MABS_OP_NONE;
        mem_rdata = 8'h00;
        repeat (16) @(posedge clk_sys);
        #1;
        chk_idle();
        srst <= 1'h0;
        @(posedge clk_sys);
        $display("test reset done");
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        $display("test table done");
        // Back-to-back operations
        op <= MABS_OP_SUBTRACT_ONE_MEMORY;
        mem_rdata <= 8'h10;
        @(posedge clk_sys);
        op <= MABS_OP_ADD_ONE_MEMORY;
        mem_rdata <= 8'h20;
        #1;
        chk("first data", 8'h0f, mem_wr.data);
        @(posedge clk_sys);
        op <= MABS_OP_NONE;
        #1;
        chk("second data", 8'h21, mem_wr.data);
        chk("second we", 8'h01, {7'h0, mem_wr.we});
        $display("test back-to-back done");
        // Power-down with kept state, ignored op, wake
        set_carry <= 1'h1;
        carry_val <= 1'h1;
        set_nibble <= 1'h1;
        nibble_val <= 1'h1;
        @(posedge clk_sys);
        set_carry <= 1'h0;
        set_nibble <= 1'h0;
        rd(MABS_REG_STATUS, 8'h06);
        do_op(MABS_OP_POWER_DOWN, 8'h00);
        chk("clear pulse", 8'h01, {7'h0, watchdog_counter_clear});
        chk("flags", 8'h16, {3'h0, flags});
        chk("halt", 8'h03, {6'h0, sys_clk_gate, exec_halted});
        chk("working kept", 8'h11, working_register);
        @(posedge clk_sys);
        #1;
        chk("clear after", 8'h00, {7'h0, watchdog_counter_clear});
        do_op(MABS_OP_SUBTRACT_ONE_TO_WORKING, 8'h05);
        chk("working asleep", 8'h11, working_register);
        chk("we asleep", 8'h00, {7'h0, mem_wr.we});
        wake <= 1'h1;
        @(posedge clk_sys);
        wake <= 1'h0;
        #1;
        repeat (8) begin
            if (exec_halted === 1'h1) begin
                @(posedge clk_sys);
                #1;
            end
        end
        chk("awake", 8'h00, {6'h0, sys_clk_gate, exec_halted});
        rd(MABS_REG_STATUS, 8'h16);
        rd(MABS_REG_WORKING, 8'h11);
        rd(4'h7, 8'h00);
        $display("test power-down done");
        // Reset in mid-run
        srst <= 1'h1;
        @(posedge clk_sys);
        srst <= 1'h0;
        #1;
        chk_idle();
        @(posedge clk_sys);
        #1;
        chk_idle();
        $display("test second reset done");
        close_out();
    end
endmodule // mabs_core_test
